// *** design/tsr_defs.svh ***
// Purpose: Offsets, field positions, reset values and codes of the trigger and status bank
// Assumes: Included by bare name from the package and the test files
// Notes: Definitions only
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
`define TSR_OFS_CONFIG 8'h1f
`define TSR_OFS_TRIGGER 8'h20
`define TSR_OFS_LATCH_CLR 8'h21
`define TSR_OFS_STATUS 8'h22
`define TSR_OFS_CMP_STATUS 8'h23
`define TSR_RST_REG16 16'h0000
`define TSR_LOCK_BIT 14
`define TSR_KEY_HI 15
`define TSR_KEY_LO 12
`define TSR_UNLOCK_CODE 4'h5
`define TSR_SRST_HI 11
`define TSR_SRST_LO 8
`define TSR_SRST_CODE 4'ha
`define TSR_PROG_BIT 1
`define TSR_RELOAD_BIT 0
`define TSR_TRIG_KEEP 16'hff03
`define TSR_CLR_KEEP 16'h8888
`define TSR_FACT_FAIL_BIT 15
`define TSR_USER_FAIL_BIT 14
`define TSR_STORE_BUSY_BIT 8
// Identifier values below are arbitrary
`define TSR_PART_ID 6'h2a
`define TSR_REV_ID 2'h1
`define TSR_AXI_TARGET 4'h0
`define TSR_AXI_WDATA 4'h4
`define TSR_AXI_CTRL 4'h8
`define TSR_AXI_STATUS 4'hc
`define TSR_AXI_RDATA 4'h0
`define TSR_AXI_OKAY 2'h0
`define TSR_AXI_SLVERR 2'h2
`endif

// *** design/tsr_device.sv ***
// Purpose: Trigger, latch clear, lock and status registers of the device end
// Assumes: Comparator inputs may be asynchronous; other inputs are synchronous to aclk
// Notes: Lock, trigger and status share one link
`timescale 1ns/100ps
module tsr_device
#(
   parameter logic [5:0] PART_ID = `TSR_PART_ID, // Arbitrary value
   parameter logic [1:0] REV_ID = `TSR_REV_ID
)
(
   input wire logic aclk,
   input wire logic aresetn,
   tsr_link_if.device link,
   input wire logic [3:0] cmp_in,
   input wire logic [3:0] dac_busy,
   input wire logic store_busy,
   input wire logic factory_check_evt,
   input wire logic user_check_evt,
   output logic store_program_trigger,
   output logic store_reload_trigger,
   output logic soft_reset,
   output logic register_lock,
   output logic [3:0] comparator_latch
);
   import tsr_pkg::*;

   // ----------------------------------------------
   // Reset and access decode
   // ----------------------------------------------
   logic rst_n;
   logic take;
   logic wr;
   logic unlock_armed;
   logic [3:0] key_field;
   logic [3:0] cmp_meta;
   logic [3:0] cmp_sync;
   logic factory_check_fail;
   logic user_store_check_fail;
   logic cfg_ok;
   tsr_word_t status_word;
   tsr_word_t next_rdata;

   assign rst_n = aresetn & ~soft_reset;
   assign take = link.req & ~link.ack;
   assign wr = take & link.we;
   assign cfg_ok = ~register_lock | unlock_armed;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         soft_reset <= 1'b0;
      else
         soft_reset <= wr && link.addr == `TSR_OFS_TRIGGER && !register_lock &&
            link.wdata[`TSR_SRST_HI:`TSR_SRST_LO] == `TSR_SRST_CODE;
   end

   // ----------------------------------------------
   // Trigger register
   // ----------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!rst_n)
      begin
         key_field <= 4'(`TSR_RST_REG16 >> `TSR_KEY_LO);
         store_program_trigger <= 1'b0;
         store_reload_trigger <= 1'b0;
      end
      else
      begin
         store_program_trigger <= 1'b0;
         store_reload_trigger <= 1'b0;
         if (wr && link.addr == `TSR_OFS_TRIGGER)
         begin
            key_field <= link.wdata[`TSR_KEY_HI:`TSR_KEY_LO];
            if (!register_lock)
            begin
               store_program_trigger <= link.wdata[`TSR_PROG_BIT];
               store_reload_trigger <= link.wdata[`TSR_RELOAD_BIT];
            end
         end
      end
   end

   // ----------------------------------------------
   // Lock and unlock sequence
   // ----------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!rst_n)
         unlock_armed <= 1'b0;
      else if (wr && link.addr == `TSR_OFS_TRIGGER)
         unlock_armed <= link.wdata[`TSR_KEY_HI:`TSR_KEY_LO] == `TSR_UNLOCK_CODE;
      else if (wr && link.addr == `TSR_OFS_CONFIG)
         unlock_armed <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!rst_n)
         register_lock <= 1'b0;
      else if (wr && link.addr == `TSR_OFS_CONFIG && cfg_ok)
         register_lock <= link.wdata[`TSR_LOCK_BIT];
   end

   // ----------------------------------------------
   // Comparator flags and latches
   // ----------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!rst_n)
      begin
         cmp_meta <= 4'h0;
         cmp_sync <= 4'h0;
      end
      else
      begin
         cmp_meta <= cmp_in;
         cmp_sync <= cmp_meta;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!rst_n)
         comparator_latch <= 4'h0;
      else
         for (int i = 0; i < 4; i++)
         begin
            if (cmp_sync[i])
               comparator_latch[i] <= 1'b1;
            else if (wr && link.addr == `TSR_OFS_LATCH_CLR && !register_lock && link.wdata[15 - 4 * i])
               comparator_latch[i] <= 1'b0;
         end
   end

   // ----------------------------------------------
   // Integrity check flags
   // ----------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!rst_n)
      begin
         factory_check_fail <= 1'b0;
         user_store_check_fail <= 1'b0;
      end
      else
      begin
         if (factory_check_evt)
            factory_check_fail <= 1'b1;
         if (user_check_evt)
            user_store_check_fail <= 1'b1;
      end
   end

   // ----------------------------------------------
   // Read path
   // ----------------------------------------------
   always_comb
   begin
      status_word = `TSR_RST_REG16;
      status_word[`TSR_FACT_FAIL_BIT] = factory_check_fail;
      status_word[`TSR_USER_FAIL_BIT] = user_store_check_fail;
      status_word[12:9] = dac_busy;
      status_word[`TSR_STORE_BUSY_BIT] = store_busy;
      status_word[7:0] = {PART_ID, REV_ID};
   end

   always_comb
   begin
      next_rdata = `TSR_RST_REG16;
      unique case (link.addr)
         `TSR_OFS_CONFIG: next_rdata[`TSR_LOCK_BIT] = register_lock;
         `TSR_OFS_TRIGGER: next_rdata[`TSR_KEY_HI:`TSR_KEY_LO] = key_field;
         `TSR_OFS_STATUS: next_rdata = status_word;
         `TSR_OFS_CMP_STATUS: next_rdata[3:0] = cmp_sync;
         default: next_rdata = `TSR_RST_REG16;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link.ack <= 1'b0;
         link.rdata <= `TSR_RST_REG16;
      end
      else
      begin
         link.ack <= take;
         if (take && !link.we)
            link.rdata <= next_rdata;
      end
   end
endmodule : tsr_device

// *** design/tsr_host.sv ***
// Purpose: Host controller driving the device link from AXI4-Lite registers
// Assumes: One outstanding AXI write and read; device answers every request
// Notes: Store operations wait for the store to be free
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
module tsr_host
(
   input wire logic aclk,
   input wire logic aresetn,
   tsr_link_if.host link,
   input wire logic [3:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [3:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   import tsr_pkg::*;

   // ----------------------------------------------
   // AXI write side
   // ----------------------------------------------
   logic aw_held;
   logic w_held;
   logic [3:0] aw_q;
   logic [31:0] w_q;
   logic do_wr;
   logic start;
   logic start_we;
   tsr_host_state_t state;
   tsr_addr_t target;
   tsr_word_t out_data;
   tsr_word_t read_back;
   tsr_word_t masked;

   assign s_awready = ~aw_held;
   assign s_wready = ~w_held;
   assign do_wr = aw_held & w_held & ~s_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_q <= 4'h0;
         w_q <= 32'h0;
         s_bvalid <= 1'b0;
         s_bresp <= `TSR_AXI_OKAY;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_held <= 1'b1;
            aw_q <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_held <= 1'b1;
            w_q <= s_wdata;
         end
         if (do_wr)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (aw_q == `TSR_AXI_STATUS || (aw_q != `TSR_AXI_TARGET && aw_q != `TSR_AXI_WDATA &&
               aw_q != `TSR_AXI_CTRL)) ? `TSR_AXI_SLVERR : `TSR_AXI_OKAY;
         end
         else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------
   // Command registers
   // ----------------------------------------------
   assign start = do_wr && state == tsr_idle && (aw_q == `TSR_AXI_WDATA || (aw_q == `TSR_AXI_CTRL && w_q[0]));
   assign start_we = aw_q == `TSR_AXI_WDATA;

   always_comb
   begin
      masked = w_q[15:0];
      if (target == `TSR_OFS_TRIGGER)
         masked = w_q[15:0] & `TSR_TRIG_KEEP;
      else if (target == `TSR_OFS_LATCH_CLR)
         masked = w_q[15:0] & `TSR_CLR_KEEP;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         target <= 8'h00;
         out_data <= `TSR_RST_REG16;
      end
      else if (do_wr && state == tsr_idle)
      begin
         if (aw_q == `TSR_AXI_TARGET && s_wstrb[0])
            target <= w_q[7:0];
         if (aw_q == `TSR_AXI_WDATA)
            out_data <= masked;
      end
   end

   // ----------------------------------------------
   // Link sequencer
   // ----------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= tsr_idle;
         link.req <= 1'b0;
         link.we <= 1'b0;
         link.addr <= 8'h00;
         link.wdata <= `TSR_RST_REG16;
         read_back <= `TSR_RST_REG16;
      end
      else
      begin
         unique case (state)
            tsr_idle:
            begin
               if (start && start_we && target == `TSR_OFS_TRIGGER &&
                  (w_q[`TSR_PROG_BIT] || w_q[`TSR_RELOAD_BIT]))
               begin
                  state <= tsr_poll;
                  link.req <= 1'b1;
                  link.we <= 1'b0;
                  link.addr <= `TSR_OFS_STATUS;
                  link.wdata <= masked;
               end
               else if (start)
               begin
                  state <= tsr_xfer;
                  link.req <= 1'b1;
                  link.we <= start_we;
                  link.addr <= target;
                  link.wdata <= masked;
               end
            end
            tsr_poll:
            begin
               if (link.ack && !link.rdata[`TSR_STORE_BUSY_BIT])
               begin
                  state <= tsr_xfer;
                  link.we <= 1'b1;
                  link.addr <= target;
               end
            end
            tsr_xfer:
            begin
               if (link.ack)
               begin
                  state <= tsr_idle;
                  link.req <= 1'b0;
                  if (!link.we)
                     read_back <= link.rdata;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------
   // AXI read side
   // ----------------------------------------------
   assign s_arready = ~s_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `TSR_AXI_OKAY;
      end
      else if (s_arvalid && s_arready)
      begin
         s_rvalid <= 1'b1;
         s_rresp <= `TSR_AXI_OKAY;
         unique case (s_araddr)
            `TSR_AXI_TARGET: s_rdata <= {24'h0, target};
            `TSR_AXI_WDATA: s_rdata <= {16'h0, out_data};
            `TSR_AXI_CTRL: s_rdata <= {16'h0, read_back};
            `TSR_AXI_STATUS: s_rdata <= {31'h0, state != tsr_idle};
            default:
            begin
               s_rdata <= 32'h0;
               s_rresp <= `TSR_AXI_SLVERR;
            end
         endcase
      end
      else if (s_rvalid && s_rready)
         s_rvalid <= 1'b0;
   end
endmodule : tsr_host

// *** design/tsr_link_if.sv ***
// Purpose: Register access link between the host controller and the device
// Assumes: One clock, host holds req until ack
// Notes: ack is a one-cycle pulse, rdata is valid with it
`timescale 1ns/100ps
interface tsr_link_if;
   logic req;
   logic we;
   tsr_pkg::tsr_addr_t addr;
   tsr_pkg::tsr_word_t wdata;
   logic ack;
   tsr_pkg::tsr_word_t rdata;
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
   modport device (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface : tsr_link_if

// *** design/tsr_pkg.sv ***
// Purpose: Link types shared by both ends of the trigger and status bank, and the host sequencer state type
// Assumes: tsr_defs.svh holds the numbers
// Notes: None
`include "tsr_defs.svh"
package tsr_pkg;
   typedef logic [7:0] tsr_addr_t;
   typedef logic [15:0] tsr_word_t;
   typedef enum logic [2:0]
   {
      tsr_idle = 3'b001,
      tsr_poll = 3'b010,
      tsr_xfer = 3'b100
   } tsr_host_state_t;
endpackage : tsr_pkg

// *** test/testbench.sv ***
// Purpose: Bench for both ends of the trigger and status bank
// Assumes: Host reached over AXI4-Lite
// Notes: Expected values come from a small model here
`timescale 1ns/100ps
`include "tsr_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
   import tsr_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [3:0] cmp_in = 0, dac_busy = 0, comparator_latch;
   logic store_busy = 0, factory_check_evt = 0, user_check_evt = 0;
   logic store_program_trigger, store_reload_trigger, soft_reset, register_lock;
   logic [3:0] s_awaddr = 0, s_araddr = 0, s_wstrb = 4'hf;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [31:0] s_wdata = 0, s_rdata, r;
   logic [1:0] s_bresp, s_rresp, resp;
   logic [15:0] v;
   logic [3:0] exp_latch;
   logic fact = 0, user = 0;
   int fails = 0, comparisons = 0, cycles = 0, seed = 32'h25dc, n_prog = 0, n_load = 0, n_srst = 0;
   tsr_link_if link();
   tsr_device tsr_device_i (.aclk(aclk), .aresetn(aresetn), .link(link), .cmp_in(cmp_in), .dac_busy(dac_busy),
      .store_busy(store_busy), .factory_check_evt(factory_check_evt), .user_check_evt(user_check_evt),
      .store_program_trigger(store_program_trigger), .store_reload_trigger(store_reload_trigger),
      .soft_reset(soft_reset), .register_lock(register_lock), .comparator_latch(comparator_latch));
   tsr_host tsr_host_i (.aclk(aclk), .aresetn(aresetn), .link(link), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   tsr_asserts tsr_asserts_i (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we), .addr(link.addr),
      .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .store_program_trigger(store_program_trigger),
      .store_reload_trigger(store_reload_trigger), .soft_reset(soft_reset), .register_lock(register_lock),
      .comparator_latch(comparator_latch));
   always #12.5 aclk = ~aclk;
   // ----
   // Model and bus tasks
   // ----
   always @(posedge aclk)
   begin
      cycles++;
      n_prog += int'(store_program_trigger === 1'b1);
      n_load += int'(store_reload_trigger === 1'b1);
      n_srst += int'(soft_reset === 1'b1);
      if (cycles == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   function automatic logic [15:0] exp_st();
      return {fact, user, 1'b0, dac_busy, store_busy, `TSR_PART_ID, `TSR_REV_ID};
   endfunction : exp_st
   task automatic tally_and_finish();
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1;
      s_wvalid <= 1;
      s_bready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 0;
         if (s_wready) s_wvalid <= 0;
      end
      while (s_bvalid !== 1'b1);
      resp = s_bresp;
      s_bready <= 0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1;
      s_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 0;
      end
      while (s_rvalid !== 1'b1);
      r = s_rdata;
      s_rready <= 0;
   endtask : axi_rd
   task automatic idle();
      do
         axi_rd(4'hc);
      while (r[0] === 1'b1);
   endtask : idle
   task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
      axi_wr(4'h0, {24'h0, a});
      axi_wr(4'h4, {16'h0, d});
      idle();
   endtask : dev_wr
   task automatic dev_rd(input logic [7:0] a);
      axi_wr(4'h0, {24'h0, a});
      axi_wr(4'h8, 32'h1);
      idle();
      axi_rd(4'h8);
      v = r[15:0];
   endtask : dev_rd
   // ----
   // Scenarios
   // ----
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      dev_rd(`TSR_OFS_TRIGGER);
      `CHK(v, 16'h0000)
      dac_busy <= 4'($random(seed));
      store_busy <= 1;
      dev_rd(`TSR_OFS_STATUS);
      `CHK(v, exp_st())
      axi_wr(4'h0, 32'h20);
      axi_wr(4'h4, 32'h2);
      repeat (20) @(posedge aclk);
      `CHK(n_prog, 0)
      store_busy <= 0;
      idle();
      `CHK(n_prog, 1)
      dev_wr(`TSR_OFS_TRIGGER, 16'h0001);
      `CHK(n_load, 1)
      dev_wr(`TSR_OFS_TRIGGER, 16'h05fc);
      `CHK(n_prog + n_load + n_srst, 2)
      axi_rd(4'h4);
      `CHK(r, 32'h500)
      dev_wr(`TSR_OFS_TRIGGER, 16'h5000);
      dev_rd(`TSR_OFS_TRIGGER);
      `CHK(v, 16'h5000)
      factory_check_evt <= 1;
      user_check_evt <= 1;
      @(posedge aclk);
      factory_check_evt <= 0;
      user_check_evt <= 0;
      fact = 1;
      user = 1;
      dev_rd(`TSR_OFS_STATUS);
      `CHK(v, exp_st())
      cmp_in <= 4'($random(seed));
      repeat (4) @(posedge aclk);
      dev_rd(`TSR_OFS_CMP_STATUS);
      `CHK(v[3:0], cmp_in)
      cmp_in <= 4'hf;
      repeat (4) @(posedge aclk);
      cmp_in <= 0;
      exp_latch = 4'hf;
      dev_wr(`TSR_OFS_LATCH_CLR, 16'h7777);
      `CHK(comparator_latch, exp_latch)
      axi_rd(4'h4);
      `CHK(r, 32'h0)
      for (int ch = 0; ch < 4; ch++)
      begin
         dev_wr(`TSR_OFS_LATCH_CLR, 16'h8000 >> (4 * ch));
         exp_latch[ch] = 0;
         `CHK(comparator_latch, exp_latch)
      end
      dev_wr(`TSR_OFS_TRIGGER, 16'h0a00);
      `CHK(n_srst, 1)
      fact = 0;
      user = 0;
      dev_rd(`TSR_OFS_STATUS);
      `CHK(v, exp_st())
      dev_wr(`TSR_OFS_CONFIG, 16'h4000);
      `CHK(register_lock, 1'b1)
      dev_wr(`TSR_OFS_TRIGGER, 16'h0002);
      `CHK(n_prog, 1)
      dev_wr(`TSR_OFS_TRIGGER, 16'h6000);
      dev_wr(`TSR_OFS_CONFIG, 16'h0000);
      `CHK(register_lock, 1'b1)
      dev_wr(`TSR_OFS_TRIGGER, 16'h5000);
      dev_wr(`TSR_OFS_CONFIG, 16'h0000);
      `CHK(register_lock, 1'b0)
      dev_wr(`TSR_OFS_STATUS, 16'hffff);
      dev_rd(`TSR_OFS_STATUS);
      `CHK(v, exp_st())
      axi_wr(4'hc, 32'h1);
      `CHK(resp, `TSR_AXI_SLVERR)
      tally_and_finish();
   end
endmodule : testbench

// *** test/tsr_asserts.sv ***
// Purpose: Link checker for the trigger and status bank
// Assumes: One clock, signals of the single link
// Notes: None
`timescale 1ns/100ps
`include "tsr_defs.svh"
module tsr_asserts
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata,
   input wire logic store_program_trigger,
   input wire logic store_reload_trigger,
   input wire logic soft_reset,
   input wire logic register_lock,
   input wire logic [3:0] comparator_latch
);
   logic tw;
   logic rt;
   assign tw = req && !ack && we && addr == `TSR_OFS_TRIGGER && !register_lock;
   assign rt = ack && !we;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // Checks
   // ----
   prog_go_a: assert property (tw && wdata[1] |=> store_program_trigger)
      else $error("program pulse missing");
   prog_cause_a: assert property (store_program_trigger |-> $past(tw) && $past(wdata[1]))
      else $error("program pulse without trigger");
   reload_go_a: assert property (tw && wdata[0] |=> store_reload_trigger)
      else $error("reload pulse missing");
   srst_go_a: assert property (tw && wdata[11:8] == `TSR_SRST_CODE |=> soft_reset)
      else $error("soft reset missing");
   srst_cause_a: assert property (soft_reset |-> $past(tw) && $past(wdata[11:8]) == `TSR_SRST_CODE)
      else $error("soft reset without code");
   readback_zero_a: assert property (rt && addr == `TSR_OFS_TRIGGER |-> rdata[11:0] == 12'h000)
      else $error("trigger bits read nonzero");
   status_id_a: assert property (rt && addr == `TSR_OFS_STATUS |-> rdata[7:0] == {`TSR_PART_ID, `TSR_REV_ID})
      else $error("identifier wrong");
   latch_fall_a: assert property ($fell(comparator_latch[0]) |->
      $past(req) && $past(we) && $past(addr) == `TSR_OFS_LATCH_CLR && $past(wdata[15])
      || $past(soft_reset) || $past(soft_reset, 2))
      else $error("latch cleared without cause");
   lock_refuse_a: assert property (register_lock && req && !ack && we && addr == `TSR_OFS_TRIGGER
      |=> !store_program_trigger && !store_reload_trigger)
      else $error("trigger taken while locked");
endmodule : tsr_asserts
